// File: design/drive_run_supervisor.sv
// Purpose: Run supervisor and frequency monitor of a motor drive
// Assumes: ctrlTick is a 1 kHz pulse on clk; pins run and jog are async
// Notes:   Drive decisions update once per tick while ce is high; status, irq and reads every ce cycle
//
// Decided for this implementation: the address-and-strobe port and the address map.
module drive_run_supervisor #(
  parameter int TICKS_PER_HOUR = drive_run_pkg::TICKS_PER_HOUR
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        ctrlTick,
  // Register port
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [15:0] rdata_q,
  output logic             irq_q,
  // Run terminals and drive state
  input  wire logic        runPin,
  input  wire logic        jogPin,
  input  wire logic        faultReset,
  input  wire logic        motorOneSel,
  input  wire logic        terminalRampSel,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic [15:0] refFreq,
  input  wire logic        refReverse,
  input  wire logic [15:0] runFreq,
  input  wire logic [15:0] loadPct,
  // Drive commands
  output logic      [15:0] targetFreq_q,
  output logic             targetRev_q,
  output logic      [15:0] rampFreq_q,
  output logic             runOut_q,
  output logic             jogOut_q,
  output logic             accelTwo_q,
  output logic             decelTwo_q,
  // Multi-function outputs
  output logic             freq_level_detect_one_q,
  output logic             freq_level_detect_two_q,
  output logic             arrive_q,
  output logic             ponReached_q,
  output logic             runReached_q,
  output logic             ponFault_q
);
  // ****************************************
  // Pin synchronisers and tick
  // ****************************************
  logic [1:0] runS_q;
  logic [1:0] jogS_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      runS_q <= 2'b00;
      jogS_q <= 2'b00;
    end
    else if (ce)
    begin
      runS_q <= {runS_q[0], runPin};
      jogS_q <= {jogS_q[0], jogPin};
    end
  wire runCmd = runS_q[1];
  wire jogCmd = jogS_q[1];
  wire tick = ce & ctrlTick;

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [15:0] cfg_q [drive_run_pkg::NCFG];
  logic [drive_run_pkg::SW-1:0] stat_q;
  logic [drive_run_pkg::SW-1:0] mask_q;
  wire wrEn = ce & wrStb;
  wire rdEn = ce & rdStb;
  genvar gi;
  generate
    for (gi = 0; gi < drive_run_pkg::NCFG; gi++)
    begin : g_cfg
      always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
          cfg_q[gi] <= drive_run_pkg::CFG_RST[gi];
        else if (wrEn && addr == 5'(gi))
          cfg_q[gi] <= wdata;
    end
  endgenerate
  drive_run_pkg::ctrl_s ctrl;
  assign ctrl = drive_run_pkg::ctrl_s'(
    cfg_q[drive_run_pkg::I_CTRL][5:0]);
  wire [15:0] lowLim = cfg_q[drive_run_pkg::I_LOWLIM];
  wire [15:0] maxF = cfg_q[drive_run_pkg::I_MAXF];

  // ****************************************
  // Frequency reference shaping
  // ****************************************
  wire below = refFreq < lowLim;
  wire stopBelow = below &&
    ctrl.belowLimitAction == drive_run_pkg::BL_STOP;
  wire revBlock = ctrl.reverseInhibit & refReverse;
  wire [15:0] baseF =
    revBlock ? 16'h0000 :
    !below ? refFreq :
    ctrl.belowLimitAction == drive_run_pkg::BL_LOWER ? lowLim :
    16'h0000;
  wire [47:0] dropP = 48'(baseF) *
    48'(cfg_q[drive_run_pkg::I_DROOP]) * 48'(loadPct);
  wire [47:0] drop = dropP / 48'(drive_run_pkg::DROOP_DIV);
  wire [15:0] droopF = (drop >= 48'(baseF)) ? 16'h0000 :
    16'(48'(baseF) - drop);

  // ****************************************
  // Jump band during ramps
  // ****************************************
  wire [15:0] halfB = cfg_q[drive_run_pkg::I_BAND] >> 1;
  wire [15:0] j1 = cfg_q[drive_run_pkg::I_JMP1];
  wire [15:0] j2 = cfg_q[drive_run_pkg::I_JMP2];
  wire jumpOn = (j1 != 16'h0000) || (j2 != 16'h0000);
  wire [16:0] j1Lo = 17'(j1) - 17'(halfB);
  wire [16:0] j1Hi = 17'(j1) + 17'(halfB);
  wire [16:0] j2Lo = 17'(j2) - 17'(halfB);
  wire [16:0] j2Hi = 17'(j2) + 17'(halfB);
  wire [16:0] rf = 17'(runFreq);
  wire in1 = j1 != 16'h0000 && !j1Lo[16] && rf > j1Lo && rf < j1Hi;
  wire in2 = j2 != 16'h0000 && !j2Lo[16] && rf > j2Lo && rf < j2Hi;
  wire ramping = accelerating | decelerating;
  wire doJump = ctrl.jumpDuringRamp & jumpOn & ramping
    & (in1 | in2);
  wire [16:0] edgeF = in1 ? (accelerating ? j1Hi : j1Lo) :
    (accelerating ? j2Hi : j2Lo);
  wire [15:0] rampF = doJump ? 16'(edgeF) : runFreq;

  // ****************************************
  // Ramp time selection
  // ****************************************
  wire freqSel = motorOneSel & ~terminalRampSel;
  wire accTwo = freqSel & accelerating &
    (runFreq < cfg_q[drive_run_pkg::I_ACCSW]);
  wire decTwo = freqSel & decelerating &
    (runFreq < cfg_q[drive_run_pkg::I_DECSW]);

  // ****************************************
  // Level detectors and arrival window
  // ****************************************
  logic [1:0] fdt_q;
  logic [1:0] fdtD;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_fdt
      wire [15:0] lvl = cfg_q[drive_run_pkg::I_LVL1 + 2 * gi];
      wire [15:0] lag = cfg_q[drive_run_pkg::I_LAG1 + 2 * gi];
      wire [31:0] lagP = 32'(lvl) * 32'(lag);
      wire [15:0] lagF =
        16'(lagP / 32'(drive_run_pkg::PCT_FULL));
      wire [15:0] offLvl = (lagF > lvl) ? 16'h0000 : lvl - lagF;
      assign fdtD[gi] = (runFreq > lvl) ? 1'b1 :
        (runFreq < offLvl) ? 1'b0 : fdt_q[gi];
    end
  endgenerate
  wire [31:0] winP = 32'(maxF) *
    32'(cfg_q[drive_run_pkg::I_WIDTH]);
  wire [15:0] win = 16'(winP / 32'(drive_run_pkg::PCT_FULL));
  wire [15:0] diff = (runFreq > targetFreq_q) ?
    runFreq - targetFreq_q : targetFreq_q - runFreq;
  wire arriveD = runOut_q & (diff <= win);

  // ****************************************
  // Hour counters
  // ****************************************
  logic [31:0] ponTicks_q;
  logic [31:0] runTicks_q;
  logic [15:0] ponHrs_q;
  logic [15:0] runHrs_q;
  wire running = runOut_q | jogOut_q;
  wire ponWrap = ponTicks_q == 32'(TICKS_PER_HOUR - 1);
  wire runWrap = runTicks_q == 32'(TICKS_PER_HOUR - 1);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ponTicks_q <= 32'h0000_0000;
      runTicks_q <= 32'h0000_0000;
      ponHrs_q <= 16'h0000;
      runHrs_q <= 16'h0000;
    end
    else if (tick)
    begin
      ponTicks_q <= ponWrap ? 32'h0000_0000 : ponTicks_q + 32'h0000_0001;
      if (ponWrap && ponHrs_q != 16'hFFFF)
        ponHrs_q <= ponHrs_q + 16'h0001;
      if (running)
      begin
        runTicks_q <= runWrap ? 32'h0000_0000 : runTicks_q + 32'h0000_0001;
        if (runWrap && runHrs_q != 16'hFFFF)
          runHrs_q <= runHrs_q + 16'h0001;
      end
    end
  wire [15:0] ponThr = cfg_q[drive_run_pkg::I_PONTHR];
  wire [15:0] runThr = cfg_q[drive_run_pkg::I_RUNTHR];
  wire ponOverD = ponThr != 16'h0000 && ponHrs_q > ponThr;
  wire ponFaultD = ponThr != 16'h0000 && ponHrs_q >= ponThr;
  wire runOverD = runThr != 16'h0000 && runHrs_q >= runThr;

  // ****************************************
  // Run supervisor
  // ****************************************
  drive_run_pkg::run_e st_q;
  drive_run_pkg::run_e stD;
  logic armed_q;
  wire protect = ctrl.startupProtect;
  wire blockNow = protect & runCmd &
    (armed_q | faultReset);
  always_comb
  begin
    stD = st_q;
    unique case (st_q)
      drive_run_pkg::ST_IDLE:
        if (runCmd)
          stD = drive_run_pkg::ST_RUN;
        else if (jogCmd)
          stD = drive_run_pkg::ST_JOG;
      drive_run_pkg::ST_RUN:
        if (jogCmd && ctrl.jogPriority)
          stD = drive_run_pkg::ST_JOG;
        else if (!runCmd)
          stD = drive_run_pkg::ST_IDLE;
      drive_run_pkg::ST_JOG:
        if (!jogCmd)
          stD = runCmd ? drive_run_pkg::ST_RUN : drive_run_pkg::ST_IDLE;
      drive_run_pkg::ST_BLOCK:
        if (!runCmd)
          stD = drive_run_pkg::ST_IDLE;
    endcase
    if (blockNow)
      stD = drive_run_pkg::ST_BLOCK;
  end
  wire runD = st_q == drive_run_pkg::ST_RUN && !stopBelow && !blockNow;
  wire jogD = st_q == drive_run_pkg::ST_JOG;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_q <= drive_run_pkg::ST_IDLE;
      armed_q <= 1'b1;
    end
    else if (tick)
    begin
      st_q <= stD;
      armed_q <= armed_q & runCmd;
    end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      targetFreq_q <= 16'h0000;
      targetRev_q <= 1'b0;
      rampFreq_q <= 16'h0000;
      runOut_q <= 1'b0;
      jogOut_q <= 1'b0;
      accelTwo_q <= 1'b0;
      decelTwo_q <= 1'b0;
      fdt_q <= 2'b00;
      arrive_q <= 1'b0;
      ponReached_q <= 1'b0;
      runReached_q <= 1'b0;
      ponFault_q <= 1'b0;
    end
    else if (tick)
    begin
      targetFreq_q <= droopF;
      targetRev_q <= refReverse & ~ctrl.reverseInhibit;
      rampFreq_q <= rampF;
      runOut_q <= runD;
      jogOut_q <= jogD;
      accelTwo_q <= accTwo;
      decelTwo_q <= decTwo;
      fdt_q <= fdtD;
      arrive_q <= arriveD;
      ponReached_q <= ponOverD;
      runReached_q <= runOverD;
      ponFault_q <= ponFaultD;
    end
  assign freq_level_detect_one_q = fdt_q[0];
  assign freq_level_detect_two_q = fdt_q[1];

  // ****************************************
  // Status, mask, interrupt and read port
  // ****************************************
  logic [drive_run_pkg::SW-1:0] evt;
  assign evt[drive_run_pkg::S_FREQ_LEVEL_DETECT_ONE] = tick & fdtD[0] & ~fdt_q[0];
  assign evt[drive_run_pkg::S_FREQ_LEVEL_DETECT_TWO] = tick & fdtD[1] & ~fdt_q[1];
  assign evt[drive_run_pkg::S_ARR] = tick & arriveD & ~arrive_q;
  assign evt[drive_run_pkg::S_PON] = tick & ponFaultD & ~ponFault_q;
  assign evt[drive_run_pkg::S_RUNH] = tick & runOverD & ~runReached_q;
  assign evt[drive_run_pkg::S_BLK] = tick & blockNow;
  wire statRd = rdEn && addr == drive_run_pkg::A_STAT;
  wire [drive_run_pkg::SW-1:0] statD =
    (statRd ? '0 : stat_q) | evt;
  wire [15:0] rdMux =
    addr < 5'(drive_run_pkg::NCFG) ? cfg_q[addr[3:0]] :
    addr == drive_run_pkg::A_STAT ? 16'(stat_q) :
    addr == drive_run_pkg::A_MASK ? 16'(mask_q) :
    addr == drive_run_pkg::A_STATE ? 16'({st_q, fdt_q, arrive_q}) :
    addr == drive_run_pkg::A_PONHRS ? ponHrs_q :
    addr == drive_run_pkg::A_RUNHRS ? runHrs_q : 16'h0000;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      stat_q <= '0;
      mask_q <= '0;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      stat_q <= statD;
      if (wrEn && addr == drive_run_pkg::A_MASK)
        mask_q <= wdata[drive_run_pkg::SW-1:0];
      rdata_q <= rdEn ? rdMux : 16'h0000;
      irq_q <= |(statD & mask_q);
    end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  rev_inhibit_a: assert property (tick && ctrl.reverseInhibit |=> !targetRev_q)
    else $error("reverse while inhibited");
  below_stop_a: assert property (tick && stopBelow |=> !runOut_q)
    else $error("ran below limit in stop mode");
  droop_drop_a: assert property (tick |=> targetFreq_q <= $past(baseF))
    else $error("droop raised frequency");
  pon_fault_a: assert property (ponReached_q |-> ponFault_q)
    else $error("exceeded without fault");
  run_hrs_a: assert property (tick && runOverD |=> runReached_q)
    else $error("run hours output missing");
  start_block_a: assert property (st_q == drive_run_pkg::ST_BLOCK |-> !runOut_q)
    else $error("ran while blocked");
  fdt_on_a: assert property (tick && runFreq > cfg_q[drive_run_pkg::I_LVL1] |=> freq_level_detect_one_q)
    else $error("level one not on");
  fdt_hold_a: assert property (tick && fdt_q[0] && runFreq >= g_fdt[0].offLvl |=> freq_level_detect_one_q)
    else $error("level one dropped inside lag");
  jog_prio_a: assert property (tick && st_q == drive_run_pkg::ST_RUN && jogCmd && ctrl.jogPriority
    && !blockNow |=> st_q == drive_run_pkg::ST_JOG)
    else $error("jog did not take priority");
  jump_off_a: assert property (!jumpOn |-> rampF == runFreq)
    else $error("jump active while disabled");
  accel_sel_a: assert property (tick && !freqSel |=> !accelTwo_q && !decelTwo_q)
    else $error("ramp switched outside motor one");
  out_tick_a: assert property (!tick |=> $stable(fdt_q) && $stable(runOut_q))
    else $error("output changed without tick");
  run_cov: cover property (tick && st_q == drive_run_pkg::ST_RUN ##1 runOut_q);
  block_cov: cover property (st_q == drive_run_pkg::ST_BLOCK ##[1:20] st_q == drive_run_pkg::ST_IDLE);
  jump_cov: cover property (tick && doJump);
endmodule

// File: design/drive_run_pkg.sv
// Purpose: Constants and types for the drive run supervisor
// Assumes: 16-bit register data, word index addressing
// Notes:   Frequencies in 0.01 Hz, lag and width in 0.1 %
package drive_run_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int AW = 5;
  localparam int DW = 16;
  localparam int NCFG = 16;
  localparam int I_CTRL = 0;
  localparam int I_DROOP = 1;
  localparam int I_PONTHR = 2;
  localparam int I_RUNTHR = 3;
  localparam int I_LVL1 = 4;
  localparam int I_LAG1 = 5;
  localparam int I_LVL2 = 6;
  localparam int I_LAG2 = 7;
  localparam int I_WIDTH = 8;
  localparam int I_ACCSW = 9;
  localparam int I_DECSW = 10;
  localparam int I_JMP1 = 11;
  localparam int I_JMP2 = 12;
  localparam int I_BAND = 13;
  localparam int I_LOWLIM = 14;
  localparam int I_MAXF = 15;
  localparam logic [4:0] A_STAT = 5'h10;
  localparam logic [4:0] A_MASK = 5'h11;
  localparam logic [4:0] A_STATE = 5'h12;
  localparam logic [4:0] A_PONHRS = 5'h13;
  localparam logic [4:0] A_RUNHRS = 5'h14;
  localparam logic [15:0] CFG_RST [NCFG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h1388, 16'h0032, 16'h1388, 16'h0032,
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h1388};
  // ****************************************
  // Scales and timing
  // ****************************************
  localparam int PCT_FULL = 1000;
  localparam int DROOP_DIV = 10000 * 1000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int HOUR_S = 3600;
  localparam int US_PER_S = 1000000;
  localparam int TICKS_PER_HOUR =
    HOUR_S * (US_PER_S / TICK_PERIOD_US);
  // ****************************************
  // Status bits
  // ****************************************
  localparam int SW = 6;
  localparam int S_FREQ_LEVEL_DETECT_ONE = 0;
  localparam int S_FREQ_LEVEL_DETECT_TWO = 1;
  localparam int S_ARR = 2;
  localparam int S_PON = 3;
  localparam int S_RUNH = 4;
  localparam int S_BLK = 5;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    BL_LOWER = 2'b00,
    BL_STOP  = 2'b01,
    BL_ZERO  = 2'b10
  } below_e;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_JOG   = 2'b10,
    ST_BLOCK = 2'b11
  } run_e;
  typedef struct packed {
    logic   jogPriority;
    logic   jumpDuringRamp;
    logic   startupProtect;
    below_e belowLimitAction;
    logic   reverseInhibit;
  } ctrl_s;
endpackage

// File: testbench/motor_terminal_model.sv
// Purpose: Motor and run-command terminal model
// Assumes: Contacts settle a few ns after the bench asks, off the clock edge
// Notes:   Shaft frequency and load follow the request directly
module motor_terminal_model (
  // Requests from the bench
  input  wire logic        runReq,
  input  wire logic        jogReq,
  input  wire logic [15:0] freqReq,
  input  wire logic [15:0] loadReq,
  // Terminals and motor feedback
  output logic             runPin,
  output logic             jogPin,
  output logic      [15:0] runFreq,
  output logic      [15:0] loadPct
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Terminal contacts
  // ********************************
  logic runDly = 1'b0;
  logic jogDly = 1'b0;
  // Each drop and reassertion of the run contact reaches the pin
  always @(runReq) runDly <= #7 runReq;
  always @(jogReq) jogDly <= #7 jogReq;
  assign runPin = runDly;
  assign jogPin = jogDly;
  // ********************************
  // Motor feedback
  // ********************************
  assign runFreq = freqReq;
  assign loadPct = loadReq;
endmodule

// File: testbench/test_drive_run_supervisor.sv
// Purpose: Self-checking bench for the run supervisor
// Assumes: Tick every 8 clocks, four ticks per hour
// Notes:   Expected values are worked out by hand
`define CHK(nm, e, g) \
  begin \
    samplesChecked++; \
    if ((g) !== (e)) \
    begin \
      errCount++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
    end \
  end
module test_drive_run_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Signals
  // ********************************
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ctrlTick, faultReset = 1'b0;
  logic [2:0] tcnt = 3'h0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata_q, refFreq = 16'h0000, runFreq, loadPct;
  logic [15:0] freqReq = 16'h0000, loadReq = 16'h0000;
  logic wrStb = 1'b0, rdStb = 1'b0, irq_q, runReq = 1'b0, jogReq = 1'b0, runPin, jogPin;
  logic motorOneSel = 1'b1, terminalRampSel = 1'b0, accelerating = 1'b0, decelerating = 1'b0;
  logic refReverse = 1'b0, targetRev_q, runOut_q, jogOut_q, accelTwo_q, decelTwo_q;
  logic [15:0] targetFreq_q, rampFreq_q;
  logic freq_level_detect_one_q, freq_level_detect_two_q, arrive_q, ponReached_q, runReached_q, ponFault_q;
  logic [15:0] lvlF [6] = '{16'h1388, 16'h1389, 16'h12C0, 16'h125C, 16'h0E74, 16'h0DAC};
  logic [5:0] lvlE1 = 6'b00_0110;
  logic [5:0] lvlE2 = 6'b01_1111;
  drive_run_pkg::ctrl_s ctrl = '0;
  int errCount = 0, samplesChecked = 0, tickCount = 0;
  // ********************************
  // Clock, tick and instances
  // ********************************
  always #10 clk = ~clk;
  always @(posedge clk) tcnt <= tcnt + 3'h1;
  assign ctrlTick = (tcnt == 3'h7);
  always @(posedge clk) if (rst_n && ctrlTick) tickCount++;
  drive_run_supervisor #(.TICKS_PER_HOUR(4)) u_drive_run_supervisor (
    .clk, .rst_n, .ce, .ctrlTick, .addr, .wdata, .wrStb, .rdStb, .rdata_q, .irq_q,
    .runPin, .jogPin, .faultReset, .motorOneSel, .terminalRampSel, .accelerating,
    .decelerating, .refFreq, .refReverse, .runFreq, .loadPct, .targetFreq_q, .targetRev_q,
    .rampFreq_q, .runOut_q, .jogOut_q, .accelTwo_q, .decelTwo_q, .freq_level_detect_one_q, .freq_level_detect_two_q,
    .arrive_q, .ponReached_q, .runReached_q, .ponFault_q);
  motor_terminal_model u_motor_terminal_model (
    .runReq, .jogReq, .freqReq, .loadReq, .runPin, .jogPin, .runFreq, .loadPct);
  // ********************************
  // Tasks
  // ********************************
  task automatic wr(input int idx, input logic [15:0] d);
    @(posedge clk);
    addr  <= idx[4:0];
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input int idx, output logic [15:0] d);
    @(posedge clk);
    addr  <= idx[4:0];
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdata_q;
  endtask
  task automatic chkRd(input int idx, input logic [15:0] e, input string nm);
    logic [15:0] d;
    rd(idx, d);
    `CHK(nm, e, d)
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff ctrlTick);
    #1;
  endtask
  task automatic setCtrl();
    wr(drive_run_pkg::I_CTRL, {10'h000, ctrl});
  endtask
  task automatic rampCase(input logic acc, dec, m1, term, input logic [15:0] f, input logic eA, eD);
    accelerating    <= acc;
    decelerating    <= dec;
    motorOneSel     <= m1;
    terminalRampSel <= term;
    freqReq         <= f;
    ticks(3);
    `CHK("accelTwo", eA, accelTwo_q)
    `CHK("decelTwo", eD, decelTwo_q)
  endtask
  task automatic giveVerdict();
    if (errCount == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ********************************
  // Watchdog
  // ********************************
  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    giveVerdict();
  end
  // ********************************
  // Tests
  // ********************************
  initial
  begin
    logic [15:0] v;
    int h;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chkRd(drive_run_pkg::I_CTRL, 16'h0000, "ctrl");
    chkRd(drive_run_pkg::I_LVL1, 16'h1388, "lvl1");
    chkRd(drive_run_pkg::I_LAG2, 16'h0032, "lag2");
    chkRd(drive_run_pkg::I_MAXF, 16'h1388, "maxf");
    chkRd(31, 16'h0000, "unmapped");
    refFreq <= 16'h0BB8;
    freqReq <= 16'h0BB8;
    runReq  <= 1'b1;
    ticks(4);
    `CHK("run", 1'b1, runOut_q)
    `CHK("target", 16'h0BB8, targetFreq_q)
    refReverse <= 1'b1;
    ticks(3);
    `CHK("rev", 1'b1, targetRev_q)
    ctrl.reverseInhibit = 1'b1;
    setCtrl();
    ticks(3);
    `CHK("revInh", 1'b0, targetRev_q)
    `CHK("revTgt", 16'h0000, targetFreq_q)
    ctrl.reverseInhibit = 1'b0;
    refReverse <= 1'b0;
    wr(drive_run_pkg::I_LOWLIM, 16'h03E8);
    refFreq <= 16'h01F4;
    for (int m = 0; m < 3; m++)
    begin
      ctrl.belowLimitAction = drive_run_pkg::below_e'(m);
      setCtrl();
      ticks(3);
      `CHK("belowRun", m != 1, runOut_q)
      if (m != 1)
        `CHK("belowTgt", (m == 0) ? 16'h03E8 : 16'h0000, targetFreq_q)
    end
    ctrl.belowLimitAction = drive_run_pkg::BL_LOWER;
    setCtrl();
    wr(drive_run_pkg::I_LOWLIM, 16'h0000);
    refFreq <= 16'h0BB8;
    wr(drive_run_pkg::I_DROOP, 16'h03E8);
    loadReq <= 16'h03E8;
    ticks(3);
    `CHK("droopFull", 16'h0A8C, targetFreq_q)
    loadReq <= 16'h01F4;
    ticks(3);
    `CHK("droopHalf", 16'h0B22, targetFreq_q)
    wr(drive_run_pkg::I_DROOP, 16'h0000);
    wr(drive_run_pkg::I_LVL2, 16'h0FA0);
    wr(drive_run_pkg::I_LAG2, 16'h0064);
    wr(drive_run_pkg::A_MASK, 16'h0000);
    rd(drive_run_pkg::A_STAT, v);
    foreach (lvlF[i])
    begin
      freqReq <= lvlF[i];
      ticks(3);
      `CHK("lvlOne", lvlE1[i], freq_level_detect_one_q)
      `CHK("lvlTwo", lvlE2[i], freq_level_detect_two_q)
    end
    `CHK("irqMasked", 1'b0, irq_q)
    wr(drive_run_pkg::A_MASK, 16'h0001);
    repeat (2) @(posedge clk);
    #1 `CHK("irqOn", 1'b1, irq_q)
    rd(drive_run_pkg::A_STAT, v);
    `CHK("statLvl", 1'b1, v[drive_run_pkg::S_FREQ_LEVEL_DETECT_ONE])
    repeat (2) @(posedge clk);
    #1 `CHK("irqClr", 1'b0, irq_q)
    wr(drive_run_pkg::I_WIDTH, 16'h0064);
    freqReq <= 16'h0BB8;
    ticks(3);
    `CHK("arrIn", 1'b1, arrive_q)
    freqReq <= 16'h1194;
    ticks(3);
    `CHK("arrOut", 1'b0, arrive_q)
    wr(drive_run_pkg::I_ACCSW, 16'h07D0);
    wr(drive_run_pkg::I_DECSW, 16'h07D0);
    rampCase(1'b1, 1'b0, 1'b1, 1'b0, 16'h03E8, 1'b1, 1'b0);
    rampCase(1'b1, 1'b0, 1'b1, 1'b0, 16'h0BB8, 1'b0, 1'b0);
    rampCase(1'b1, 1'b0, 1'b1, 1'b1, 16'h03E8, 1'b0, 1'b0);
    rampCase(1'b1, 1'b0, 1'b0, 1'b0, 16'h03E8, 1'b0, 1'b0);
    rampCase(1'b0, 1'b1, 1'b1, 1'b0, 16'h0BB8, 1'b0, 1'b0);
    rampCase(1'b0, 1'b1, 1'b1, 1'b0, 16'h03E8, 1'b0, 1'b1);
    wr(drive_run_pkg::I_JMP1, 16'h07D0);
    wr(drive_run_pkg::I_BAND, 16'h00C8);
    ctrl.jumpDuringRamp = 1'b1;
    setCtrl();
    rampCase(1'b1, 1'b0, 1'b1, 1'b0, 16'h07D0, 1'b0, 1'b0);
    `CHK("jumpUp", 16'h0834, rampFreq_q)
    accelerating <= 1'b0;
    decelerating <= 1'b1;
    ticks(3);
    `CHK("jumpDown", 16'h076C, rampFreq_q)
    wr(drive_run_pkg::I_JMP1, 16'h0000);
    ticks(3);
    `CHK("jumpOff", 16'h07D0, rampFreq_q)
    decelerating <= 1'b0;
    jogReq <= 1'b1;
    ticks(4);
    `CHK("jogIgnored", 1'b0, jogOut_q)
    ctrl.jogPriority = 1'b1;
    setCtrl();
    ticks(3);
    `CHK("jogTaken", 1'b1, jogOut_q)
    jogReq <= 1'b0;
    ticks(4);
    ctrl.startupProtect = 1'b1;
    setCtrl();
    @(posedge clk iff tcnt == 3'h6);
    faultReset <= 1'b1;
    @(posedge clk);
    faultReset <= 1'b0;
    ticks(3);
    `CHK("blocked", 1'b0, runOut_q)
    runReq <= 1'b0;
    ticks(3);
    runReq <= 1'b1;
    ticks(4);
    `CHK("rearmed", 1'b1, runOut_q)
    h = tickCount / 4 + 3;
    wr(drive_run_pkg::I_PONTHR, h[15:0]);
    wr(drive_run_pkg::I_RUNTHR, 16'hFDE8);
    ticks(2);
    `CHK("ponEarly", 1'b0, ponFault_q)
    `CHK("ponOutEarly", 1'b0, ponReached_q)
    `CHK("runEarly", 1'b0, runReached_q)
    ticks(20);
    `CHK("ponFault", 1'b1, ponFault_q)
    `CHK("ponOut", 1'b1, ponReached_q)
    wr(drive_run_pkg::I_RUNTHR, 16'h0001);
    ticks(3);
    `CHK("runHours", 1'b1, runReached_q)
    ce      <= 1'b0;
    freqReq <= 16'h1770;
    ticks(3);
    `CHK("ceFrozen", 1'b0, freq_level_detect_one_q)
    ce <= 1'b1;
    ticks(3);
    `CHK("ceResumed", 1'b1, freq_level_detect_one_q)
    @(posedge clk iff ctrlTick);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    @(posedge clk iff ctrlTick);
    rst_n <= 1'b1;
    setCtrl();
    ticks(3);
    `CHK("ponBlocked", 1'b0, runOut_q)
    runReq <= 1'b0;
    ticks(3);
    runReq <= 1'b1;
    ticks(4);
    `CHK("ponRearmed", 1'b1, runOut_q)
    giveVerdict();
  end
endmodule
